//--- hdl/ocs_top.sv
// oscillator source control: apb registers, source switch, ext drive control
// assumes an apb master on CLK and an async stable level from the ext detector
`timescale 1ns/100ps

module ocs_top
  import ocs_pkg::*;
#(
  parameter logic [6:0] CAL_FACTORY = 7'h40,       // arbitrary stand-in trim
  parameter int         EXT_FREQ_HZ = 25_000_000   // expected external rate
) (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              EXT_OSC_STABLE,
  output logic [2:0]             SYSTEM_CLOCK_SOURCE,
  output logic                   SWITCH_BUSY,
  output logic                   LP_OSC_EN,
  output logic                   SS_ENABLE,
  output logic [6:0]             OSC_CAL_TRIM,
  output logic [2:0]             SS_STEP,
  output logic                   EXT_OSC_EN,
  output logic [2:0]             EXT_MODE,
  output logic [2:0]             EXT_FREQ_CODE,
  output logic                   EXT_DIV2_EN,
  output logic                   EXT_PERIPH_EN,
  output logic                   EXT_OSC_VALID
);

  // ==========================================================
  // helpers

  // period of a source in bus cycles, rounded up, at least one
  function automatic logic [SW_CNT_W-1:0] src_cycles(input ocs_src_t s);
    int f;
    f = PREC_FREQ_HZ;
    case (s)
      SRC_PREC:    f = PREC_FREQ_HZ;
      SRC_EXT:     f = EXT_FREQ_HZ;
      SRC_LP_DIV8: f = LP_FREQ_HZ / LP_DIV;
      SRC_RTC:     f = RTC_FREQ_HZ;
      SRC_LP:      f = LP_FREQ_HZ;
      default:     f = PREC_FREQ_HZ;
    endcase
    return SW_CNT_W'((CLK_FREQ_HZ + f - 1) / f);
  endfunction

  // sources fed by the low-power oscillator
  function automatic logic uses_lp(input ocs_src_t s);
    return (s == SRC_LP) || (s == SRC_LP_DIV8);
  endfunction

  // ==========================================================
  // state
  ocs_src_t            sel_req;     // requested source
  ocs_src_t            sel_active;  // source driving system_clock now
  ocs_src_t            sw_target;   // source being switched to
  logic                sw_busy;     // switchover in flight
  logic [SW_CNT_W-1:0] sw_cnt;      // cycles left in switchover
  logic [6:0]          cal_trim;    // precision osc trim
  logic                ss_en;       // dither enable
  ocs_ext_mode_t       ext_mode;    // external drive mode
  logic                ext_on;      // drive enable, a flop so the pin sees no decode
  logic [2:0]          ext_fcn;     // ext_freq_control_code
  logic                ext_stable;  // synchronised detector level
  logic                ext_valid;   // qualified valid flag
  logic                lp_en;       // low-power osc enable
  logic [2:0]          ss_step;     // from triangle generator
  logic                acc;         // apb access completes this edge
  logic                wr_acc;      // completing write
  logic [31:0]         next_rdata;  // read mux
  logic                next_err;    // unmapped address
  logic [SW_CNT_W-1:0] cyc_old;     // period of source left behind
  logic [SW_CNT_W-1:0] cyc_new;     // period of source taken up

  assign acc    = PSEL && PENABLE && PREADY;
  assign wr_acc = acc && PWRITE;

  // ==========================================================
  // apb handshake: one wait state, so each access takes three cycles
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : next_rdata;
        PSLVERR <= next_err;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (PADDR)
      OFS_CLK_SEL:  next_rdata[SRC_MSB:0] = sel_req;
      OFS_OSC_CAL:  next_rdata[7:0] = {ss_en, cal_trim};
      OFS_EXT_CTRL: next_rdata[7:0] = {ext_valid, ext_mode, 1'b0, ext_fcn};
      OFS_STATUS:   next_rdata[5:0] = {ext_valid, lp_en, sw_busy, sel_active};
      default:      next_err = 1'b1;  // unmapped: error, data zero
    endcase
  end

  // ==========================================================
  // source request register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sel_req <= SRC_LP;
    end else if (wr_acc && PADDR == OFS_CLK_SEL) begin
      case (PWDATA[SRC_MSB:0])
        SRC_PREC, SRC_EXT, SRC_LP_DIV8, SRC_RTC, SRC_LP:
          sel_req <= ocs_src_t'(PWDATA[SRC_MSB:0]);
        default: sel_req <= sel_req;  // reserved: keep old choice
      endcase
    end
  end

  // ==========================================================
  // calibration register; dither bit is not factory trimmed
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cal_trim <= CAL_FACTORY;
      ss_en    <= 1'b0;
    end else if (wr_acc && PADDR == OFS_OSC_CAL) begin
      cal_trim <= PWDATA[CAL_MSB:0];
      ss_en    <= PWDATA[SS_EN_BIT];
    end
  end

  // ==========================================================
  // external drive control: mode, code and enable in one word
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ext_mode <= EXT_OFF;
      ext_on   <= 1'b0;
      ext_fcn  <= 3'h0;
    end else if (wr_acc && PADDR == OFS_EXT_CTRL) begin
      ext_fcn <= PWDATA[FCN_MSB:0];
      case (PWDATA[EXT_MODE_MSB:EXT_MODE_LSB])
        EXT_OFF, EXT_CMOS, EXT_CMOS_DIV2, EXT_RC, EXT_CAP, EXT_XTAL, EXT_XTAL_DIV2: begin
          ext_mode <= ocs_ext_mode_t'(PWDATA[EXT_MODE_MSB:EXT_MODE_LSB]);
          ext_on   <= (PWDATA[EXT_MODE_MSB:EXT_MODE_LSB] != EXT_OFF);
        end
        default: ext_mode <= ext_mode;  // undefined code ignored
      endcase
    end
  end

  // ==========================================================
  // switchover: the new source is taken only after one period
  // of the slower oscillator so no runt system_clock pulse escapes
  assign cyc_old = src_cycles(sel_active);
  assign cyc_new = src_cycles(sel_req);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sel_active <= SRC_LP;
      sw_target  <= SRC_LP;
      sw_busy    <= 1'b0;
      sw_cnt     <= '0;
    end else if (!sw_busy) begin
      if (sel_req != sel_active) begin
        sw_target <= sel_req;
        sw_busy   <= 1'b1;
        sw_cnt    <= ((cyc_old > cyc_new) ? cyc_old : cyc_new) - SW_CNT_W'(1);
      end
    end else if (sw_cnt == '0) begin
      sel_active <= sw_target;
      sw_busy    <= 1'b0;
    end else begin
      sw_cnt <= sw_cnt - SW_CNT_W'(1);
    end
  end

  // ==========================================================
  // low-power osc gating; started at the start of a switch
  // toward it so it is running by the time it is taken
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      lp_en <= 1'b1;
    end else begin
      lp_en <= uses_lp(sel_active) || (sw_busy && uses_lp(sw_target));
    end
  end

  // ==========================================================
  // external valid: the detector is analog, so resynchronise
  // two-flop synchroniser
  ocs_sync u_sync (
    .CLK      (CLK),
    .RST_B    (RST_B),
    .async_in (EXT_OSC_STABLE),
    .sync_out (ext_stable)
  );

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ext_valid <= 1'b0;
    end else begin
      ext_valid <= ext_stable && (ext_mode != EXT_OFF) &&
                   (ext_mode != EXT_CMOS) && (ext_mode != EXT_CMOS_DIV2);
    end
  end

  // ==========================================================
  // spread spectrum triangle
  ocs_spread u_spread (
    .CLK    (CLK),
    .RST_B  (RST_B),
    .enable (ss_en),
    .step   (ss_step)
  );

  // ==========================================================
  // drive outputs; divider and peripheral enable are flops
  // so the analog side never sees a decode glitch
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      EXT_DIV2_EN   <= 1'b0;
      EXT_PERIPH_EN <= 1'b0;
    end else begin
      EXT_DIV2_EN   <= (ext_mode == EXT_XTAL_DIV2) || (ext_mode == EXT_CMOS_DIV2);
      EXT_PERIPH_EN <= (ext_mode != EXT_OFF);
    end
  end

  assign SYSTEM_CLOCK_SOURCE = sel_active;
  assign SWITCH_BUSY   = sw_busy;
  assign LP_OSC_EN     = lp_en;
  assign SS_ENABLE     = ss_en;
  assign OSC_CAL_TRIM  = cal_trim;
  assign SS_STEP       = ss_step;
  assign EXT_OSC_EN    = ext_on;
  assign EXT_MODE      = ext_mode;
  assign EXT_FREQ_CODE = ext_fcn;
  assign EXT_OSC_VALID = ext_valid;

  // ==========================================================
  // checks
  property p_reset_lp;
    @(posedge CLK) disable iff (!RST_B)
    $past(!RST_B) |-> (sel_active == SRC_LP) && (sel_req == SRC_LP);
  endproperty
  a_reset_lp: assert property (p_reset_lp)
    else $error("source not low-power after reset");

  property p_cmos_invalid;
    @(posedge CLK) disable iff (!RST_B)
    $past(ext_mode == EXT_CMOS || ext_mode == EXT_CMOS_DIV2) |-> !ext_valid;
  endproperty
  a_cmos_invalid: assert property (p_cmos_invalid)
    else $error("valid set in cmos mode");

  property p_lp_on;
    @(posedge CLK) disable iff (!RST_B)
    (sel_active == SRC_LP) ##1 (sel_active == SRC_LP) |-> lp_en;
  endproperty
  a_lp_on: assert property (p_lp_on)
    else $error("low-power osc off while selected");

  property p_lp_off;
    @(posedge CLK) disable iff (!RST_B)
    (!sw_busy && !uses_lp(sel_active))[*2] |-> !lp_en;
  endproperty
  a_lp_off: assert property (p_lp_off)
    else $error("low-power osc on while unused");

  property p_ss_off;
    @(posedge CLK) disable iff (!RST_B)
    !ss_en |=> (ss_step == 3'h0);
  endproperty
  a_ss_off: assert property (p_ss_off)
    else $error("dither step with dither off");

  property p_ss_bound;
    @(posedge CLK) disable iff (!RST_B)
    ss_step <= 3'(SS_STEPS_MAX);
  endproperty
  a_ss_bound: assert property (p_ss_bound)
    else $error("dither deeper than limit");

  property p_sw_hold;
    @(posedge CLK) disable iff (!RST_B)
    (sw_busy && sw_cnt != '0) |=> $stable(sel_active) && sw_busy;
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("source changed before period");

  property p_sw_land;
    @(posedge CLK) disable iff (!RST_B)
    (sw_busy && sw_cnt == '0) |=> !sw_busy && (sel_active == $past(sw_target));
  endproperty
  a_sw_land: assert property (p_sw_land)
    else $error("switch did not land");

  property p_reserved;
    @(posedge CLK) disable iff (!RST_B)
    (wr_acc && PADDR == OFS_CLK_SEL && PWDATA[SRC_MSB:0] > SRC_LP) |=> $stable(sel_req);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved source code accepted");

  property p_ss_bit;
    @(posedge CLK) disable iff (!RST_B)
    (wr_acc && PADDR == OFS_OSC_CAL) |=> (ss_en == $past(PWDATA[SS_EN_BIT]));
  endproperty
  a_ss_bit: assert property (p_ss_bit)
    else $error("dither enable not from bit 7");

  property p_ext_en;
    @(posedge CLK) disable iff (!RST_B)
    ext_on == (ext_mode != EXT_OFF);
  endproperty
  a_ext_en: assert property (p_ext_en)
    else $error("ext drive enable disagrees with mode");

endmodule // ocs_top

//--- shared/ocs_pkg.sv
// oscillator source control: shared constants, register map and encodings
// assumes a single 40 MHz bus clock; all rates below are counted in it
package ocs_pkg;

  // ==========================================================
  // register map, apb byte addresses
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CLK_SEL  = 8'h00;   // system clock source request
  localparam logic [7:0]  OFS_OSC_CAL  = 8'h04;   // precision trim and dither enable
  localparam logic [7:0]  OFS_EXT_CTRL = 8'h08;   // external drive control
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;   // live state, read only

  // ==========================================================
  // field positions
  localparam int SS_EN_BIT     = 7;   // dither enable inside osc_calibration
  localparam int CAL_MSB       = 6;   // calibration code is [6:0]
  localparam int EXT_VALID_BIT = 7;   // read-only valid flag in ext_osc_control
  localparam int EXT_MODE_MSB  = 6;
  localparam int EXT_MODE_LSB  = 4;
  localparam int FCN_MSB       = 2;   // ext_freq_control_code is [2:0]
  localparam int SRC_MSB       = 2;   // source select is [2:0]

  // ==========================================================
  // encodings
  typedef enum logic [2:0] {
    SRC_PREC    = 3'b000,
    SRC_EXT     = 3'b001,
    SRC_LP_DIV8 = 3'b010,
    SRC_RTC     = 3'b011,
    SRC_LP      = 3'b100
  } ocs_src_t;

  typedef enum logic [2:0] {
    EXT_OFF       = 3'b000,
    EXT_CMOS      = 3'b010,
    EXT_CMOS_DIV2 = 3'b011,
    EXT_RC        = 3'b100,
    EXT_CAP       = 3'b101,
    EXT_XTAL      = 3'b110,
    EXT_XTAL_DIV2 = 3'b111
  } ocs_ext_mode_t;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_HZ  = 40_000_000;
  localparam int PREC_FREQ_HZ = 24_500_000;
  localparam int LP_FREQ_HZ   = 20_000_000;
  localparam int LP_DIV       = 8;
  localparam int RTC_FREQ_HZ  = 32_768;
  localparam int SW_CNT_W     = 11;            // holds the slowest period, rtc
  localparam int SS_DIV       = 384;           // triangle period in osc cycles
  localparam int SS_STEPS_MAX = 6;             // 1.6 % in 0.26 % steps
  localparam int SS_STEP_CYC  = SS_DIV / (2 * SS_STEPS_MAX);
  localparam int SS_CNT_W     = 5;

endpackage : ocs_pkg

//--- hdl/ocs_sync.sv
// oscillator source control: two-stage level synchroniser
// assumes the input may toggle at any time relative to CLK
`timescale 1ns/100ps

module ocs_sync (
  input  wire logic CLK,       // bus clock
  input  wire logic RST_B,     // sync reset, active low
  input  wire logic async_in,  // level from outside the domain
  output logic      sync_out   // safe level
);

  logic meta;  // first stage, read by the second stage only

  // ==========================================================
  // two flops; nothing else looks at meta
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // ocs_sync

//--- hdl/ocs_spread.sv
// oscillator source control: stepped triangle for spread spectrum
// assumes enable is a registered level on the same clock
`timescale 1ns/100ps

module ocs_spread
  import ocs_pkg::*;
(
  input  wire logic       CLK,     // bus clock, stands in for the osc rate
  input  wire logic       RST_B,   // sync reset, active low
  input  wire logic       enable,  // dither on
  output logic [2:0]      step     // steps below nominal, never above
);

  logic [SS_CNT_W-1:0] div_cnt;   // cycles within one step
  logic                going_up;  // triangle direction

  // ==========================================================
  // one full triangle = 2 * max steps * step length = 384 cycles
  always_ff @(posedge CLK) begin
    if (!RST_B || !enable) begin
      div_cnt  <= '0;
      going_up <= 1'b1;
      step     <= 3'h0;
    end else if (div_cnt == SS_CNT_W'(SS_STEP_CYC - 1)) begin
      div_cnt <= '0;
      if (going_up) begin
        step     <= step + 3'h1;
        going_up <= (step + 3'h1) != 3'(SS_STEPS_MAX);
      end else begin
        step     <= step - 3'h1;
        going_up <= (step - 3'h1) == 3'h0;
      end
    end else begin
      div_cnt <= div_cnt + SS_CNT_W'(1);
    end
  end

endmodule // ocs_spread

//--- tb/ocs_ext_osc_model.sv
// oscillator source control: behavioural external oscillator and valid detector
// assumes run comes from the block's drive enable; stable is async to CLK
`timescale 1ns/100ps

module ocs_ext_osc_model (
  input  wire logic        run,       // drive circuit enabled
  input  wire logic [15:0] start_ns,  // startup time, prompt or slow
  output logic             stable     // detector level
);
  // ==========================================================
  // startup
  // the detector rises in every mode, cmos too; hiding it is the block's job
  // cmos clock on second pin only
  initial begin
    stable = 1'b0;
    forever begin
      wait (run === 1'b1);
      #(start_ns);
      // a drop during startup leaves the detector low
      if (run === 1'b1) begin
        stable = 1'b1;
      end
      wait (run !== 1'b1);
      stable = 1'b0;
    end
  end
endmodule // ocs_ext_osc_model

//--- tb/tb_top.sv
// oscillator source control: self-checking bench over apb
// assumes ocs_top and the external oscillator model beside it
`timescale 1ns/100ps

module tb_top
  import ocs_pkg::*;
;
  // ==========================================================
  // signals
  localparam int EXT_HZ = 25_000_000;     // external rate handed to the block
  logic        clk = 1'b0;                // 40 MHz bus clock
  logic        rst_b = 1'b0;              // sync reset, active low
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, stable, busy, lp_en, ss_en, ext_en, div2, per_en, valid;
  logic [2:0]  src, step, mode, code;
  logic [6:0]  trim;
  logic [15:0] start_ns = 16'd107;        // oscillator startup time
  int          err_total = 0;
  int          n_checks = 0;
  int          hz[5] = '{PREC_FREQ_HZ, EXT_HZ, LP_FREQ_HZ / LP_DIV, RTC_FREQ_HZ, LP_FREQ_HZ};
  logic [2:0]  cur = SRC_LP;               // source in use as the bench sees it

  always #12.5 clk = ~clk;

  ocs_top #(.EXT_FREQ_HZ(EXT_HZ)) uut (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_OSC_STABLE(stable), .SYSTEM_CLOCK_SOURCE(src),
    .SWITCH_BUSY(busy), .LP_OSC_EN(lp_en), .SS_ENABLE(ss_en), .OSC_CAL_TRIM(trim),
    .SS_STEP(step), .EXT_OSC_EN(ext_en), .EXT_MODE(mode), .EXT_FREQ_CODE(code),
    .EXT_DIV2_EN(div2), .EXT_PERIPH_EN(per_en), .EXT_OSC_VALID(valid)
  );

  ocs_ext_osc_model ext_osc (.run(ext_en), .start_ns(start_ns), .stable(stable));

  // ==========================================================
  // helpers
  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // apb transfer; waits for pready with a bound, never a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(n, 0);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // read and compare data and error flag
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic ex_er);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(e, ex_er);
  endtask

  function automatic int per(input logic [2:0] s);
    return (CLK_FREQ_HZ + hz[s] - 1) / hz[s];
  endfunction

  // request a source, count busy cycles, expect the slower period
  task automatic sw(input logic [2:0] s);
    int n;
    int k;
    wr(OFS_CLK_SEL, {29'h0, s});
    for (k = 0; k < 5 && busy !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    n = 0;
    for (k = 0; k < 2000 && busy === 1'b1; k++) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, (per(s) > per(cur)) ? per(s) : per(cur));
    chk(src, s);
    cur = s;
    repeat (2) @(posedge clk);
    chk(lp_en, (s == SRC_LP || s == SRC_LP_DIV8));
  endtask

  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: whole run is well under 20000 cycles
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end

  // ==========================================================
  // tests
  initial begin
    logic [2:0]    tri_s[384];
    logic [2:0]    prev;
    logic [2:0]    top;
    logic [2:0]    fc;
    logic [31:0]   r;
    logic          e;
    int            i;
    int            n;
    ocs_ext_mode_t mt[6] = '{EXT_XTAL, EXT_XTAL_DIV2, EXT_RC, EXT_CAP, EXT_CMOS, EXT_CMOS_DIV2};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(src, SRC_LP);
    chk(lp_en, 1'b1);
    chk(trim, 7'h40);
    rdc(OFS_CLK_SEL, 32'h4, 1'b0);
    rdc(OFS_OSC_CAL, 32'h40, 1'b0);
    rdc(OFS_EXT_CTRL, 32'h0, 1'b0);
    wr(OFS_STATUS, 32'hFF);
    rdc(OFS_STATUS, 32'h14, 1'b0);
    rdc(8'h10, 32'h0, 1'b1);
    // dither: two full periods, second must repeat the first
    wr(OFS_OSC_CAL, 32'hC0);
    top = 3'h0;
    n = 0;
    for (i = 0; i < 768; i++) begin
      @(posedge clk);
      #1;
      if (i < 384) begin
        tri_s[i] = step;
      end else begin
        chk(step, tri_s[i - 384]);
      end
      if (i > 0 && i < 384 && step !== prev) begin
        n++;
      end
      if (step > top) begin
        top = step;
      end
      prev = step;
    end
    chk(ss_en, 1'b1);
    chk(top, 3'd6);
    chk(n, 12);
    wr(OFS_OSC_CAL, 32'h2A);
    @(posedge clk);
    #1;
    chk(step, 3'd0);
    chk(trim, 7'h2A);
    // external modes, prompt and slow startups alternating
    for (i = 0; i < 6; i++) begin
      // a 25 MHz crystal takes the top code
      fc = (mt[i] == EXT_XTAL || mt[i] == EXT_XTAL_DIV2) ? 3'h7 : 3'(i * 3);
      start_ns <= i[0] ? 16'd2007 : 16'd107;
      wr(OFS_EXT_CTRL, {25'h0, mt[i], 1'b0, fc});
      @(posedge clk);
      #1;
      chk(ext_en, 1'b1);
      chk(mode, mt[i]);
      chk(code, fc);
      chk(div2, (mt[i] == EXT_XTAL_DIV2 || mt[i] == EXT_CMOS_DIV2));
      @(posedge clk);
      chk(per_en, 1'b1);
      if (mt[i][2]) begin
        // software polls the valid flag before any switch
        n = 0;
        do begin
          apb(1'b0, OFS_EXT_CTRL, 32'h0, r, e);
          n++;
        end while (r[7] !== 1'b1 && n < 100);
        chk(r, {24'h0, 1'b1, mt[i], 1'b0, fc});
        chk(valid, 1'b1);
        if (i == 0) begin
          sw(SRC_LP_DIV8);
          sw(SRC_PREC);
          sw(SRC_RTC);
          sw(SRC_PREC);
          sw(SRC_EXT);
          sw(SRC_LP);
        end
      end else begin
        repeat (200) @(posedge clk);
        rdc(OFS_EXT_CTRL, {24'h0, 1'b0, mt[i], 1'b0, fc}, 1'b0);
        chk(valid, 1'b0);
      end
      wr(OFS_EXT_CTRL, 32'h0);
      repeat (6) @(posedge clk);
      chk(ext_en, 1'b0);
      chk(per_en, 1'b0);
    end
    // a reset in mid-run falls back to low-power and the factory trim
    sw(SRC_PREC);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    cur = SRC_LP;
    chk(src, SRC_LP);
    chk(trim, 7'h40);
    rdc(OFS_CLK_SEL, 32'h4, 1'b0);
    // refused codes keep the old value; the code field of that write still lands
    wr(OFS_EXT_CTRL, 32'h13);
    rdc(OFS_EXT_CTRL, 32'h3, 1'b0);
    wr(OFS_CLK_SEL, 32'h5);
    rdc(OFS_CLK_SEL, 32'h4, 1'b0);
    chk(busy, 1'b0);
    chk(src, SRC_LP);
    end_of_test();
  end
endmodule // tb_top
